// ### config_prom_pkg.sv
// constants, carriers and state codes of the configuration readout sequencer
// assumes a 200 MHz core clock and an 8-bit parallel configuration port
package config_prom_pkg;

  localparam int CLK_PERIOD_NS   = 5;
  localparam int OSC_HALF_NS     = 15;
  localparam int OSC_HALF_CYC    = (OSC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CO_HIGH_NS      = 10;
  localparam int CO_HIGH_CYC     = (CO_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 4;
  localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] CO_LOAD  = CNT_W'(CO_HIGH_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  localparam int DATA_W_DEF      = 8;
  localparam int REV_W           = 2;
  localparam int REV_ADDR_W_DEF  = 16;
  localparam logic [REV_W-1:0] REV_RESET = 2'h0;

  // pin group, synchroniser idle values
  typedef struct packed {
    logic             ce_n;
    logic             oe_n;
    logic             busy;
    logic             cf_n;
    logic             ext_sel_n;
    logic [REV_W-1:0] rev;
  } pin_in_t;
  localparam int      PIN_IN_W  = 7;
  localparam pin_in_t PIN_RESET = 7'h4f;

  // programmed control bits
  typedef struct packed {
    logic             osc_select;
    logic             config_clock_output_en;
    logic             parallel;
    logic             decompress;
    logic [REV_W-1:0] rev_internal;
  } cfg_bits_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1,
    ST_HOLD = 2'h3,
    ST_DONE = 2'h2
  } seq_state_t;

endpackage

// ### config_prom_sequencer.sv
// readout sequencer: address counter, clock source, clock output, chain enable
// assumes the array answers mem_addr_o combinationally with mem_data_i/mem_valid_i
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// - chain enable low only when enabled, out of reset, past terminal count.
// - chain enable returns high once reset line low or chip enable high.
// - chain enable feeds the next memory's chip enable in a cascade.
// - selection pin low: revision comes from the two revision pins.
// - selection pin high: revision comes from internal revision bits.
// - two-bit revision pins choose which stored revision is read out.
// - busy counts only in parallel mode; undriven busy reads as zero.
// - busy high: counter frozen, current data word held on pins.
// - after busy falls, next clock edge presents the next address's data.
// - serial mode or decompression: busy is ignored.
// - control bit enables clock output, sourced from selected clock.
// - selected clock edge advances counter if data ready, enabled, out of reset.
// - data is valid at the rising edge of the clock output.
// - clock output off while chip enable high or reset line low.
// - with decompression, clock output off while data not ready.
// - disabled clock output is high impedance.
// - chip enable high: standby, counter reset, data and clock floated.
// - reset line low: counter reset, outputs floated; device pulls it during reset.
// - configuration pulse rising: sample revision, load its start address.
// - pin clock advances only with busy low and configuration pulse high.
module config_prom_sequencer
  import config_prom_pkg::*;
#(
  parameter int DATA_W     = DATA_W_DEF,
  parameter int REV_ADDR_W = REV_ADDR_W_DEF,
  parameter int ADDR_W     = REV_ADDR_W + REV_W
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              cfg_clk_i,
  input  wire cfg_bits_t         cfg_i,
  input  wire logic              chip_enable_n_i,
  input  wire logic              oe_reset_n_i,
  output logic                   oe_reset_n_o,
  output logic                   oe_reset_n_oe_o,
  input  wire logic              busy_i,
  input  wire logic              config_pulse_n_i,
  input  wire logic              pin_revision_choose_n_i,
  input  wire logic              revision_pick_bit0_i,
  input  wire logic              revision_pick_bit1_i,
  output logic [ADDR_W-1:0]      mem_addr_o,
  input  wire logic [DATA_W-1:0] mem_data_i,
  input  wire logic              mem_valid_i,
  output logic [DATA_W-1:0]      config_data_pins_o,
  output logic                   config_data_pins_oe_o,
  output logic                   config_clock_output_o,
  output logic                   config_clock_output_oe_o,
  output logic                   chain_enable_out_n_o,
  output logic [REV_W-1:0]       rev_active_o,
  output seq_state_t             seq_state_o
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  pin_in_t          pins_raw;
  pin_in_t          pin_meta_reg;
  pin_in_t          pin_sync_reg;
  logic             link_rst_meta_reg;
  logic             link_rst_reg;
  logic             link_tog_reg;
  logic             tog_meta_reg;
  logic             tog_sync_reg;
  logic             tog_prev_reg;
  logic             cf_prev_reg;
  logic [CNT_W-1:0] osc_cnt_reg;
  logic             osc_level_reg;
  logic [CNT_W-1:0] co_cnt_reg;
  logic             co_reg;
  logic             co_oe_reg;
  logic             data_oe_reg;
  logic             ceo_n_reg;
  logic             own_reset_reg;
  logic [REV_W-1:0] rev_latched_reg;
  logic [ADDR_W-1:0]  addr_reg;
  logic [ADDR_W-1:0]  addr_next;
  logic [DATA_W-1:0]  data_reg;
  seq_state_t       state_reg;
  seq_state_t       state_next;

  wire              active;
  wire              busy_eff;
  wire              stall;
  wire              pin_rise;
  wire              osc_tick;
  wire              osc_rise;
  wire              src_edge;
  wire              gate_ok;
  wire              advance;
  wire              at_tc;
  wire              cf_rise;
  wire [REV_W-1:0]  rev_sel;
  wire [ADDR_W-1:0] start_latched;
  wire [ADDR_W-1:0] start_sel;
  wire              co_src;
  wire              co_en;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  assign pins_raw = '{ce_n:      chip_enable_n_i,
                      oe_n:      oe_reset_n_i,
                      busy:      busy_i,
                      cf_n:      config_pulse_n_i,
                      ext_sel_n: pin_revision_choose_n_i,
                      rev:       {revision_pick_bit1_i, revision_pick_bit0_i}};

  for (genvar i = 0; i < PIN_IN_W; i++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        pin_meta_reg[i] <= PIN_RESET[i];
        pin_sync_reg[i] <= PIN_RESET[i];
      end else begin
        pin_meta_reg[i] <= pins_raw[i];
        pin_sync_reg[i] <= pin_meta_reg[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link clock domain: edge toggle of the clock input pin

  always_ff @(posedge cfg_clk_i) begin
    link_rst_meta_reg <= reset_i;
    link_rst_reg      <= link_rst_meta_reg;
  end

  always_ff @(posedge cfg_clk_i) begin
    if (link_rst_reg) begin
      link_tog_reg <= 1'b0;
    end else begin
      link_tog_reg <= ~link_tog_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      tog_prev_reg <= 1'b0;
    end else begin
      tog_meta_reg <= link_tog_reg;
      tog_sync_reg <= tog_meta_reg;
      tog_prev_reg <= tog_sync_reg;
    end
  end

  assign pin_rise = tog_sync_reg ^ tog_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // internal oscillator, stopped in standby

  assign osc_tick = (osc_cnt_reg == OSC_LAST);
  assign osc_rise = osc_tick & ~osc_level_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i || !active) begin
      osc_cnt_reg   <= CNT_ZERO;
      osc_level_reg <= 1'b0;
    end else if (osc_tick) begin
      osc_cnt_reg   <= CNT_ZERO;
      osc_level_reg <= ~osc_level_reg;
    end else begin
      osc_cnt_reg   <= osc_cnt_reg + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // qualifiers

  assign active   = ~pin_sync_reg.ce_n & pin_sync_reg.oe_n;
  assign busy_eff = cfg_i.parallel & ~cfg_i.decompress & pin_sync_reg.busy;
  assign stall    = busy_eff | ~mem_valid_i;
  assign src_edge = cfg_i.osc_select ? osc_rise : pin_rise;
  assign gate_ok  = active & mem_valid_i & ~busy_eff
                  & (cfg_i.osc_select | pin_sync_reg.cf_n);
  assign advance  = src_edge & gate_ok
                  & ((state_reg == ST_RUN) | (state_reg == ST_HOLD));
  assign at_tc    = &addr_reg[REV_ADDR_W-1:0];
  assign cf_rise  = pin_sync_reg.cf_n & ~cf_prev_reg;

  // revision source
  assign rev_sel  = pin_sync_reg.ext_sel_n ? cfg_i.rev_internal
                                           : pin_sync_reg.rev;
  assign start_latched = {rev_latched_reg, {REV_ADDR_W{1'b0}}};
  assign start_sel     = {rev_sel, {REV_ADDR_W{1'b0}}};

  //////////////////////////////////////////////////////////////////////////////
  // sequence state

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (active) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (!active) state_next = ST_IDLE;
        else if (cf_rise) state_next = ST_RUN;
        else if (advance && at_tc) state_next = ST_DONE;
        else if (stall) state_next = ST_HOLD;
      end
      ST_HOLD: begin
        if (!active) state_next = ST_IDLE;
        else if (!cf_rise && advance && at_tc) state_next = ST_DONE;
        else if (!stall || cf_rise) state_next = ST_RUN;
      end
      ST_DONE: begin
        if (!active) state_next = ST_IDLE;
        else if (cf_rise) state_next = ST_RUN;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // address counter; stops at terminal count, the done state marks "beyond"
  always_comb begin
    addr_next = addr_reg;
    if (!active) begin
      addr_next = start_latched;
    end else if (cf_rise) begin
      addr_next = start_sel;
    end else if (advance && !at_tc) begin
      addr_next = addr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg       <= ST_IDLE;
      addr_reg        <= '0;
      rev_latched_reg <= REV_RESET;
      cf_prev_reg     <= 1'b1;
    end else begin
      state_reg   <= state_next;
      addr_reg    <= addr_next;
      cf_prev_reg <= pin_sync_reg.cf_n;
      if (cf_rise) begin
        rev_latched_reg <= rev_sel;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data pins, held while frozen

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_reg    <= '0;
      data_oe_reg <= 1'b0;
    end else begin
      data_oe_reg <= active;
      if (advance) begin
        data_reg <= mem_data_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock output: rises one cycle after the data it qualifies

  assign co_src = cfg_i.osc_select ? osc_level_reg : (co_cnt_reg != CNT_ZERO);
  assign co_en  = cfg_i.config_clock_output_en & active
                & ~(cfg_i.decompress & ~mem_valid_i)
                & (state_reg != ST_IDLE);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      co_cnt_reg <= CNT_ZERO;
      co_reg     <= 1'b0;
      co_oe_reg  <= 1'b0;
    end else begin
      if (pin_rise) begin
        co_cnt_reg <= CO_LOAD;
      end else if (co_cnt_reg != CNT_ZERO) begin
        co_cnt_reg <= co_cnt_reg - 4'h1;
      end
      co_reg    <= co_en & co_src;
      co_oe_reg <= co_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // chain enable and own reset drive

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ceo_n_reg     <= 1'b1;
      own_reset_reg <= 1'b1;
    end else begin
      ceo_n_reg     <= ~(active & (state_reg == ST_DONE));
      own_reset_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign mem_addr_o               = addr_reg;
  assign config_data_pins_o       = data_reg;
  assign config_data_pins_oe_o    = data_oe_reg;
  assign config_clock_output_o    = co_reg;
  assign config_clock_output_oe_o = co_oe_reg;
  assign chain_enable_out_n_o     = ceo_n_reg;
  assign oe_reset_n_o             = 1'b0;
  assign oe_reset_n_oe_o          = own_reset_reg;
  assign rev_active_o             = rev_latched_reg;
  assign seq_state_o              = state_reg;

endmodule

// ### config_prom_properties.sv
// assertions on the readout sequencer ports
// assumes core clock clk_i and synchronous active-high reset_i
`timescale 1ns/100ps
module config_prom_properties
  import config_prom_pkg::*;
#(
  parameter int DATA_W     = DATA_W_DEF,
  parameter int REV_ADDR_W = REV_ADDR_W_DEF,
  parameter int ADDR_W     = REV_ADDR_W + REV_W
) (
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire cfg_bits_t         cfg_i,
  input wire logic              chip_enable_n_i,
  input wire logic              oe_reset_n_i,
  input wire logic              busy_i,
  input wire logic              mem_valid_i,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [DATA_W-1:0] config_data_pins_o,
  input wire logic              config_data_pins_oe_o,
  input wire logic              config_clock_output_oe_o,
  input wire logic              chain_enable_out_n_o,
  input wire seq_state_t        seq_state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  sequence s_ce_off;
    chip_enable_n_i [*4];
  endsequence
  sequence s_oe_low;
    (!oe_reset_n_i) [*4];
  endsequence
  sequence s_busy_held;
    (cfg_i.parallel && !cfg_i.decompress && busy_i) [*4];
  endsequence
  property p_chain_cause;
    $fell(chain_enable_out_n_o) |-> $past(seq_state_o) == ST_DONE;
  endproperty
  property p_ce_off;
    s_ce_off |-> chain_enable_out_n_o && !config_data_pins_oe_o && !config_clock_output_oe_o;
  endproperty
  property p_oe_off;
    s_oe_low |-> chain_enable_out_n_o && !config_data_pins_oe_o && !config_clock_output_oe_o;
  endproperty
  property p_busy_freeze;
    s_busy_held |-> $stable(mem_addr_o) && $stable(config_data_pins_o);
  endproperty
  property p_no_valid;
    !mem_valid_i |=> mem_addr_o == $past(mem_addr_o) || mem_addr_o[REV_ADDR_W-1:0] == '0;
  endproperty
  property p_step;
    $changed(mem_addr_o) |->
      mem_addr_o == $past(mem_addr_o) + 1'b1 || mem_addr_o[REV_ADDR_W-1:0] == '0;
  endproperty
  property p_clk_en;
    (!cfg_i.config_clock_output_en) [*2] |-> !config_clock_output_oe_o;
  endproperty
  property p_decomp;
    (cfg_i.decompress && !mem_valid_i) [*2] |-> !config_clock_output_oe_o;
  endproperty
  a_chain_cause: assert property (p_chain_cause)
    else $error("chain enable fell outside done");
  a_ce_off: assert property (p_ce_off)
    else $error("outputs still active with chip enable high");
  a_oe_off: assert property (p_oe_off)
    else $error("outputs still active with reset line low");
  a_busy_freeze: assert property (p_busy_freeze)
    else $error("address or data moved under busy");
  a_no_valid: assert property (p_no_valid)
    else $error("address advanced without data");
  a_step: assert property (p_step)
    else $error("address jumped");
  a_clk_en: assert property (p_clk_en)
    else $error("clock output on while disabled");
  a_decomp: assert property (p_decomp)
    else $error("clock output on while data not ready");
endmodule
bind config_prom_sequencer config_prom_properties #(
  .DATA_W(DATA_W), .REV_ADDR_W(REV_ADDR_W), .ADDR_W(ADDR_W)
) chk_u (
  .clk_i, .reset_i, .cfg_i, .chip_enable_n_i, .oe_reset_n_i, .busy_i, .mem_valid_i,
  .mem_addr_o, .config_data_pins_o, .config_data_pins_oe_o, .config_clock_output_oe_o,
  .chain_enable_out_n_o, .seq_state_o
);

// ### fpga_port_model.sv
// far-side model: configuration port sampling data on clock-output rises
// assumes a pulled-up clock wire and a pulled-down busy wire
`timescale 1ns/100ps
module fpga_port_model #(
  parameter int DATA_W = 8
) (
  input  wire logic              cclk_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              stall_i,
  output logic                   busy_o,
  output logic                   busy_oe_o,
  output logic [DATA_W-1:0]      last_o,
  output int                     words_o
);
  ////////////////////////////////////////
  initial words_o = 0;
  initial last_o = '0;
  assign busy_o = 1'b1;
  // released busy falls to the pull-down
  assign busy_oe_o = stall_i;
  always @(posedge cclk_i) begin
    last_o <= data_i;
    words_o <= words_o + 1;
  end
endmodule

// ### tb.sv
// self-checking bench for the readout sequencer and a far-side port model
// assumes a 4-bit region per revision so terminal count comes quickly
`timescale 1ns/100ps
module tb;
  import config_prom_pkg::*;
  localparam int RAW = 4;
  localparam int AW  = RAW + REV_W;
  // link clock runs through reset so its own domain leaves reset defined
  logic clk = 0, reset = 1, lclk = 0, run = 1, ce_n = 1, oer_n = 1, cf_n = 1;
  logic ext_n = 1, valid = 0, stall = 0;
  logic [1:0] pins = '0;
  cfg_bits_t cfg = '0;
  logic [AW-1:0] addr;
  logic [7:0] dout, last;
  logic oer_o, oer_oe, dout_oe, co, co_oe, chain_n, busy_v, busy_oe;
  logic [1:0] rev;
  int n_errors = 0, cmp_count = 0, cyc = 0, words;
  tri1 oer_w, co_w;
  tri0 busy_w;
  wire [7:0] data_w = dout_oe ? dout : 8'hzz;
  assign oer_w = oer_oe ? oer_o : 1'bz;
  assign oer_w = oer_n ? 1'bz : 1'b0;
  assign co_w = co_oe ? co : 1'bz;
  assign busy_w = busy_oe ? busy_v : 1'bz;
  always #2.5 clk = ~clk;
  always #16 if (run) lclk = ~lclk;
  function automatic logic [7:0] mem_of(logic [AW-1:0] a);
    return 8'(a) ^ 8'h5a;
  endfunction
  config_prom_sequencer #(.REV_ADDR_W(RAW)) dut_u (
    .clk_i(clk), .reset_i(reset), .cfg_clk_i(lclk), .cfg_i(cfg), .chip_enable_n_i(ce_n),
    .oe_reset_n_i(oer_w), .oe_reset_n_o(oer_o), .oe_reset_n_oe_o(oer_oe), .busy_i(busy_w),
    .config_pulse_n_i(cf_n), .pin_revision_choose_n_i(ext_n), .revision_pick_bit0_i(pins[0]),
    .revision_pick_bit1_i(pins[1]), .mem_addr_o(addr), .mem_data_i(mem_of(addr)),
    .mem_valid_i(valid), .config_data_pins_o(dout), .config_data_pins_oe_o(dout_oe),
    .config_clock_output_o(co), .config_clock_output_oe_o(co_oe),
    .chain_enable_out_n_o(chain_n), .rev_active_o(rev), .seq_state_o());
  fpga_port_model port_u (.cclk_i(co_w), .data_i(data_w), .stall_i(stall), .busy_o(busy_v),
    .busy_oe_o(busy_oe), .last_o(last), .words_o(words));
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic restart(input cfg_bits_t c);
    @(posedge clk);
    ce_n <= 1'b1;
    cfg <= c;
    tick(6);
    ce_n <= 1'b0;
    tick(4);
  endtask
  task automatic t_stream();
    int w0;
    restart(6'h38);
    w0 = words;
    valid <= 1'b1;
    tick(40);
    valid <= 1'b0;
    // count before the free-running clock output rises again without data
    tick(2);
    chk(words - w0, addr[RAW-1:0]);
    chk(last, mem_of(addr - 1'b1));
    tick(8);
    chk(co_oe, 1'b1);
    $display("test stream done");
  endtask
  task automatic t_busy();
    logic [AW-1:0] a0;
    logic [7:0] d0;
    int i;
    for (int k = 0; k < 3; k++) begin
      restart(k == 0 ? 6'h38 : (k == 1 ? 6'h3c : 6'h30));
      valid <= 1'b1;
      stall <= 1'b1;
      tick(20);
      a0 = addr;
      d0 = dout;
      tick(20);
      if (k == 0) begin
        chk(addr, a0);
        chk(dout, d0);
        stall <= 1'b0;
        for (i = 0; i < 20 && addr == a0; i++) tick(1);
        chk(addr, a0 + 1'b1);
        chk(dout, mem_of(a0));
      end else
        chk(addr != a0, 1'b1);
      stall <= 1'b0;
      valid <= 1'b0;
    end
    $display("test busy done");
  endtask
  task automatic t_decomp();
    restart(6'h3c);
    tick(6);
    chk(co_oe, 1'b0);
    chk(addr[RAW-1:0], 4'h0);
    valid <= 1'b1;
    tick(4);
    chk(co_oe, 1'b1);
    valid <= 1'b0;
    restart(6'h28);
    valid <= 1'b1;
    tick(8);
    chk(co_oe, 1'b0);
    chk(addr[RAW-1:0] != 0, 1'b1);
    valid <= 1'b0;
    $display("test decompress done");
  endtask
  task automatic t_rev();
    logic [1:0] e;
    restart(6'h38);
    for (int i = 0; i < 8; i++) begin
      ext_n <= i[2];
      pins <= i[1:0];
      cfg.rev_internal <= ~i[1:0];
      cf_n <= 1'b0;
      tick(4);
      cf_n <= 1'b1;
      tick(6);
      e = i[2] ? ~i[1:0] : i[1:0];
      chk(rev, e);
      chk(addr, {e, 4'h0});
    end
    $display("test revision done");
  endtask
  task automatic t_pinclk();
    int w0;
    logic [AW-1:0] a0;
    restart(6'h18);
    valid <= 1'b1;
    w0 = words;
    run = 1'b1;
    #(32*5);
    @(negedge lclk) run = 1'b0;
    tick(10);
    chk(addr[RAW-1:0] != 0, 1'b1);
    chk(words - w0, addr[RAW-1:0]);
    cf_n <= 1'b0;
    tick(4);
    a0 = addr;
    run = 1'b1;
    #(32*4);
    @(negedge lclk) run = 1'b0;
    tick(6);
    chk(addr, a0);
    cf_n <= 1'b1;
    valid <= 1'b0;
    $display("test pin clock done");
  endtask
  task automatic t_term();
    int i;
    for (int k = 0; k < 2; k++) begin
      restart(6'h38);
      valid <= 1'b1;
      for (i = 0; i < 300 && chain_n !== 1'b0; i++) tick(1);
      chk(chain_n, 1'b0);
      chk(addr[RAW-1:0], 4'hf);
      if (k == 0) ce_n <= 1'b1;
      else oer_n <= 1'b0;
      tick(5);
      chk(chain_n, 1'b1);
      chk(co_oe, 1'b0);
      chk(data_w, 8'hzz);
      oer_n <= 1'b1;
      valid <= 1'b0;
    end
    $display("test terminal done");
  endtask
  task automatic summarize();
    $display("counts: compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    tick(9);
    chk(oer_oe, 1'b1);
    chk(oer_w, 1'b0);
    tick(1);
    reset <= 1'b0;
    tick(4);
    chk(oer_oe, 1'b0);
    chk(dout_oe, 1'b0);
    repeat (3) @(posedge lclk);
    @(negedge lclk) run = 1'b0;
    t_stream();
    t_busy();
    t_decomp();
    t_rev();
    t_pinclk();
    t_term();
    summarize();
  end
endmodule
